/* File: logic/cmd_parser_pkg.sv */
package cmd_parser_pkg;
  localparam logic [7:0] CH_OPEN   = 8'h3C;
  localparam logic [7:0] CH_CLOSE  = 8'h3E;
  localparam logic [7:0] CH_COMMA  = 8'h2C;
  localparam logic [7:0] CH_QUERY  = 8'h3F;
  localparam logic [7:0] CH_K      = 8'h4B;
  localparam logic [7:0] CH_Z      = 8'h5A;
  localparam logic [7:0] CH_A      = 8'h41;
  localparam logic [7:0] CH_ESC    = 8'h5C;
  localparam logic [7:0] CH_NUL    = 8'h00;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] PC_RESET  = 8'h04;
  localparam logic [7:0] PC_REQ    = 8'h05;
  localparam logic [7:0] PC_STX    = 8'h02;
  localparam logic [7:0] PC_ETX    = 8'h03;
  localparam logic [7:0] PC_ACK    = 8'h06;
  localparam logic [7:0] PC_NAK    = 8'h15;
  localparam logic [7:0] PC_XON    = 8'h11;
  localparam logic [7:0] PC_XOFF   = 8'h13;
  localparam int         CODE_DIGITS = 3;
  localparam logic [7:0] FIELD_RESET = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_FIRST = 4'b0001,
    ST_CODE  = 4'b0010,
    ST_SEP   = 4'b0011,
    ST_DATA  = 4'b0100,
    ST_ESC1  = 4'b0101,
    ST_ESC2  = 4'b0110,
    ST_QEND  = 4'b0111,
    ST_INIT  = 4'b1000,
    ST_DROP  = 4'b1001
  } state_type;
endpackage : cmd_parser_pkg

/* File: logic/param_store.sv */
`timescale 1ns/1ps
// Setting memory: one byte per field slot, staged write, registered read.
module param_store #(
  parameter int AW = 6
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule : param_store

/* File: logic/serial_config_command_parser.sv */
`timescale 1ns/1ps
// Byte-stream parser for bracketed configuration commands. Each field
// holds one byte value; the store is indexed by group slot and field.
module serial_config_command_parser
  import cmd_parser_pkg::*;
#(
  parameter int NGROUPS = 4,
  parameter int NFIELDS = 8,
  parameter logic [11:0] GROUP_CODE0 = 12'h100,
  parameter logic [11:0] GROUP_CODE1 = 12'h141,
  parameter logic [11:0] GROUP_CODE2 = 12'h142,
  parameter logic [11:0] GROUP_CODE3 = 12'h145
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  // Received byte stream
  input  wire logic       RX_VALID,
  input  wire logic [7:0] RX_DATA,
  // Settings readback port
  input  wire logic [4:0] RD_ADDR,
  output logic      [7:0] RD_DATA,
  // Command results
  output logic            CFG_APPLY,
  output logic            CFG_SAVE,
  output logic            STATUS_REQ,
  output logic            QUERY_REQ,
  output logic [11:0]     QUERY_CODE,
  output logic            CMD_ERROR,
  // Protocol control decode
  output logic            PROTO_RESET,
  output logic            PROTO_REQUEST,
  output logic            PROTO_STX,
  output logic            PROTO_ETX,
  output logic            PROTO_ACK,
  output logic            PROTO_NAK,
  output logic            TX_PAUSED,
  // Calibration
  input  wire logic       CAL_START,
  input  wire logic       CAL_END,
  input  wire logic       DECODE_OK,
  output logic            CAL_PASS,
  output logic            CAL_FAIL
);
  localparam int FW = $clog2(NFIELDS);
  localparam int GW = $clog2(NGROUPS);
  localparam int AW = GW + FW;

  state_type  state_q;
  logic [11:0] code_q;
  logic [1:0]  digit_q;
  logic [FW:0] field_q;
  logic [7:0]  esc_q;
  logic [7:0]  stage_q [0:NFIELDS-1];
  logic [NFIELDS-1:0] dirty_q;
  logic        commit_q;
  logic [FW:0] cidx_q;
  logic [GW-1:0] grp_q;
  logic        grp_hit;
  logic [GW-1:0] grp_sel;
  logic        pending_q;
  logic        cal_run_q;
  logic        cal_seen_q;
  logic [3:0]  hex_val;
  logic        is_hex;
  logic        ctl_byte;

  // Hex digit decode for escaped data; upper-case digits only.
  always_comb begin
    is_hex  = 1'b1;
    hex_val = 4'h0;
    if (RX_DATA >= 8'h30 && RX_DATA <= 8'h39) begin
      hex_val = RX_DATA[3:0];
    end else if (RX_DATA >= 8'h41 && RX_DATA <= 8'h46) begin
      hex_val = RX_DATA[3:0] + 4'h9;
    end else begin
      is_hex = 1'b0;
    end
  end

  always_comb begin
    grp_hit = 1'b1;
    grp_sel = '0;
    case (code_q)
      GROUP_CODE0: grp_sel = GW'(0);
      GROUP_CODE1: grp_sel = GW'(1);
      GROUP_CODE2: grp_sel = GW'(2);
      GROUP_CODE3: grp_sel = GW'(3);
      default:     grp_hit = 1'b0;
    endcase
  end

  // Control bytes outside a command frame are protocol traffic; inside a
  // frame they are never decoded, and within a field they are ordinary data.
  assign ctl_byte = RX_VALID && (state_q == ST_IDLE || state_q == ST_INIT);

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      PROTO_RESET   <= 1'b0;
      PROTO_REQUEST <= 1'b0;
      PROTO_STX     <= 1'b0;
      PROTO_ETX     <= 1'b0;
      PROTO_ACK     <= 1'b0;
      PROTO_NAK     <= 1'b0;
      TX_PAUSED     <= 1'b0;
    end else begin
      PROTO_RESET   <= ctl_byte && RX_DATA == PC_RESET;
      PROTO_REQUEST <= ctl_byte && RX_DATA == PC_REQ;
      PROTO_STX     <= ctl_byte && RX_DATA == PC_STX;
      PROTO_ETX     <= ctl_byte && RX_DATA == PC_ETX;
      PROTO_ACK     <= ctl_byte && RX_DATA == PC_ACK;
      PROTO_NAK     <= ctl_byte && RX_DATA == PC_NAK;
      if (ctl_byte && RX_DATA == PC_XOFF) begin
        TX_PAUSED <= 1'b1;
      end else if (ctl_byte && RX_DATA == PC_XON) begin
        TX_PAUSED <= 1'b0;
      end
    end
  end

  // Parser state and result pulses.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_q    <= ST_IDLE;
      code_q     <= 12'h000;
      digit_q    <= 2'b00;
      field_q    <= '0;
      esc_q      <= 8'h00;
      dirty_q    <= '0;
      commit_q   <= 1'b0;
      grp_q      <= '0;
      pending_q  <= 1'b0;
      CFG_APPLY  <= 1'b0;
      CFG_SAVE   <= 1'b0;
      STATUS_REQ <= 1'b0;
      QUERY_REQ  <= 1'b0;
      QUERY_CODE <= 12'h000;
      CMD_ERROR  <= 1'b0;
    end else begin
      CFG_APPLY  <= 1'b0;
      CFG_SAVE   <= 1'b0;
      STATUS_REQ <= 1'b0;
      QUERY_REQ  <= 1'b0;
      CMD_ERROR  <= 1'b0;
      if (commit_q && cidx_q == (FW+1)'(NFIELDS - 1)) begin
        commit_q <= 1'b0;
        dirty_q  <= '0;
      end
      if (RX_VALID) begin
        if (RX_DATA == CH_NUL && state_q != ST_IDLE) begin
          state_q   <= ST_IDLE;
          CMD_ERROR <= 1'b1;
          dirty_q   <= '0;
        end else begin
          case (state_q)
            ST_IDLE, ST_INIT: begin
              if (RX_DATA == CH_OPEN) begin
                state_q <= ST_FIRST;
              end
            end
            ST_FIRST: begin
              // A frame cut by a NUL must not leave a stale Z or A marker.
              esc_q   <= 8'h00;
              digit_q <= 2'b00;
              code_q  <= 12'h000;
              field_q <= '0;
              if (RX_DATA == CH_K) begin
                state_q <= ST_CODE;
              end else if (RX_DATA == CH_QUERY) begin
                state_q <= ST_QEND;
              end else if (RX_DATA == CH_Z || RX_DATA == CH_A) begin
                // Case-sensitive: lower-case letters fall to the drop path.
                esc_q   <= RX_DATA;
                state_q <= ST_QEND;
              end else begin
                state_q   <= ST_DROP;
                CMD_ERROR <= 1'b1;
              end
            end
            ST_CODE: begin
              if (RX_DATA >= CH_ZERO && RX_DATA <= 8'h39) begin
                code_q  <= {code_q[7:0], RX_DATA[3:0]};
                digit_q <= digit_q + 2'b01;
                if (digit_q == 2'(CODE_DIGITS - 1)) begin
                  state_q <= ST_SEP;
                end
              end else begin
                state_q   <= ST_DROP;
                CMD_ERROR <= 1'b1;
              end
            end
            ST_SEP: begin
              if (!grp_hit) begin
                state_q   <= ST_DROP;
                CMD_ERROR <= 1'b1;
              end else if (RX_DATA == CH_QUERY) begin
                QUERY_CODE <= code_q;
                esc_q      <= CH_QUERY;
                state_q    <= ST_QEND;
              end else if (RX_DATA == CH_COMMA) begin
                grp_q   <= grp_sel;
                state_q <= ST_DATA;
              end else if (RX_DATA == CH_CLOSE) begin
                state_q <= ST_INIT;
              end else begin
                state_q   <= ST_DROP;
                CMD_ERROR <= 1'b1;
              end
            end
            ST_DATA: begin
              if (RX_DATA == CH_COMMA) begin
                field_q <= field_q + 1'b1;
              end else if (RX_DATA == CH_CLOSE) begin
                // Untouched and omitted fields stay clean and keep values.
                commit_q  <= 1'b1;
                pending_q <= 1'b1;
                state_q   <= ST_INIT;
              end else if (RX_DATA == CH_OPEN) begin
                state_q   <= ST_FIRST;
                CMD_ERROR <= 1'b1;
                dirty_q   <= '0;
              end else if (RX_DATA == CH_ESC) begin
                state_q <= ST_ESC1;
              end else if (field_q < (FW+1)'(NFIELDS)) begin
                dirty_q[field_q[FW-1:0]] <= 1'b1;
              end
            end
            ST_ESC1: begin
              esc_q   <= {4'h0, hex_val};
              state_q <= is_hex ? ST_ESC2 : ST_DROP;
              CMD_ERROR <= !is_hex;
            end
            ST_ESC2: begin
              state_q <= is_hex ? ST_DATA : ST_DROP;
              CMD_ERROR <= !is_hex;
              if (is_hex && field_q < (FW+1)'(NFIELDS)) begin
                dirty_q[field_q[FW-1:0]] <= 1'b1;
              end
            end
            ST_QEND: begin
              state_q <= (RX_DATA == CH_CLOSE) ? ST_INIT : ST_DROP;
              CMD_ERROR <= RX_DATA != CH_CLOSE;
              if (RX_DATA == CH_CLOSE) begin
                if (esc_q == CH_Z || esc_q == CH_A) begin
                  CFG_APPLY <= 1'b1;
                  CFG_SAVE  <= esc_q == CH_Z;
                  pending_q <= 1'b0;
                end else if (esc_q == CH_QUERY) begin
                  QUERY_REQ <= 1'b1;
                end else begin
                  STATUS_REQ <= 1'b1;
                end
              end
              esc_q <= 8'h00;
            end
            ST_DROP: begin
              if (RX_DATA == CH_OPEN) begin
                state_q <= ST_FIRST;
              end else if (RX_DATA == CH_CLOSE) begin
                state_q <= ST_IDLE;
              end
            end
            default: state_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // Staging of field bytes; the escaped pair composes one data byte.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      for (int i = 0; i < NFIELDS; i++) begin
        stage_q[i] <= FIELD_RESET;
      end
    end else if (RX_VALID && field_q < (FW+1)'(NFIELDS)) begin
      if (state_q == ST_DATA && RX_DATA != CH_COMMA && RX_DATA != CH_CLOSE &&
          RX_DATA != CH_OPEN && RX_DATA != CH_ESC && RX_DATA != CH_NUL) begin
        stage_q[field_q[FW-1:0]] <= RX_DATA;
      end else if (state_q == ST_ESC2 && is_hex) begin
        stage_q[field_q[FW-1:0]] <= {esc_q[3:0], hex_val};
      end
    end
  end

  // Commit walks the staged fields; only dirty ones are written.
  // The walk takes NFIELDS cycles, so a following command's fields must
  // not start before it ends; a short gap between commands covers this.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cidx_q <= '0;
    end else if (commit_q) begin
      cidx_q <= cidx_q + 1'b1;
    end else begin
      cidx_q <= '0;
    end
  end

  param_store #(.AW(AW)) u_store (
    .clk   (CORE_CLK),
    .rst   (RESET),
    .we    (commit_q && dirty_q[cidx_q[FW-1:0]]),
    .waddr ({grp_q, cidx_q[FW-1:0]}),
    .wdata (stage_q[cidx_q[FW-1:0]]),
    .raddr (RD_ADDR[AW-1:0]),
    .rdata (RD_DATA)
  );

  // Calibration passes only when a decode succeeded while it ran.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cal_run_q  <= 1'b0;
      cal_seen_q <= 1'b0;
      CAL_PASS   <= 1'b0;
      CAL_FAIL   <= 1'b0;
    end else begin
      CAL_PASS <= 1'b0;
      CAL_FAIL <= 1'b0;
      if (CAL_START) begin
        cal_run_q  <= 1'b1;
        cal_seen_q <= DECODE_OK;
      end else if (cal_run_q && CAL_END) begin
        cal_run_q <= 1'b0;
        CAL_PASS  <= cal_seen_q || DECODE_OK;
        CAL_FAIL  <= !(cal_seen_q || DECODE_OK);
      end else if (cal_run_q && DECODE_OK) begin
        cal_seen_q <= 1'b1;
      end
    end
  end
endmodule : serial_config_command_parser

/* File: verification/cmd_parser_asserts.sv */
`timescale 1ns/1ps
module cmd_parser_asserts
  import cmd_parser_pkg::*;
(
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RESET,
  // Byte stream and calibration inputs
  input wire logic       RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic       CAL_START,
  input wire logic       DECODE_OK,
  // Results
  input wire logic       CFG_APPLY,
  input wire logic       CFG_SAVE,
  input wire logic       STATUS_REQ,
  input wire logic       PROTO_RESET,
  input wire logic       PROTO_REQUEST,
  input wire logic       PROTO_STX,
  input wire logic       PROTO_ETX,
  input wire logic       PROTO_ACK,
  input wire logic       PROTO_NAK,
  input wire logic       TX_PAUSED,
  input wire logic       CAL_PASS
);
  logic in_frame_q;
  logic seen_q;
  logic idle_byte;
  assign idle_byte = RX_VALID && !in_frame_q;
  // Frame tracking ends only at a close, so no control byte follows a NUL
  // abort before the next closing bracket.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) in_frame_q <= 1'b0;
    else if (RX_VALID && RX_DATA == CH_OPEN) in_frame_q <= 1'b1;
    else if (RX_VALID && RX_DATA == CH_CLOSE) in_frame_q <= 1'b0;
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) seen_q <= 1'b0;
    else if (CAL_START) seen_q <= DECODE_OK;
    else if (DECODE_OK) seen_q <= 1'b1;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  a_reset_decode: assert property (
    idle_byte && RX_DATA == PC_RESET |=> PROTO_RESET)
    else $error("reset byte not decoded");
  a_request_decode: assert property (
    idle_byte && RX_DATA == PC_REQ |=> PROTO_REQUEST)
    else $error("request byte not decoded");
  a_text_marks: assert property (
    idle_byte && RX_DATA == PC_STX |=> PROTO_STX && !PROTO_ETX)
    else $error("start of text not decoded");
  a_end_mark: assert property (
    idle_byte && RX_DATA == PC_ETX |=> PROTO_ETX && !PROTO_STX)
    else $error("end of text not decoded");
  a_ack_decode: assert property (
    idle_byte && RX_DATA == PC_ACK |=> PROTO_ACK && !PROTO_NAK)
    else $error("acknowledge not decoded");
  a_nak_decode: assert property (
    idle_byte && RX_DATA == PC_NAK |=> PROTO_NAK && !PROTO_ACK)
    else $error("negative acknowledge not decoded");
  a_pause_set: assert property (
    idle_byte && RX_DATA == PC_XOFF |=> TX_PAUSED)
    else $error("stop byte did not pause");
  a_pause_clear: assert property (
    idle_byte && RX_DATA == PC_XON |=> !TX_PAUSED)
    else $error("resume byte did not clear pause");
  a_data_inert: assert property (
    RX_VALID && in_frame_q |=> $stable(TX_PAUSED) && !PROTO_RESET)
    else $error("control byte in frame acted as protocol");
  a_apply_close: assert property (
    CFG_APPLY || CFG_SAVE |-> $past(RX_VALID && RX_DATA == CH_CLOSE))
    else $error("apply without closing bracket");
  a_save_apply: assert property (
    CFG_SAVE |-> CFG_APPLY)
    else $error("save without apply");
  a_status_close: assert property (
    STATUS_REQ |-> $past(RX_VALID && RX_DATA == CH_CLOSE))
    else $error("status request without closing bracket");
  a_cal_decode: assert property (
    CAL_PASS |-> seen_q)
    else $error("calibration passed without a decode");
  c_status: cover property (STATUS_REQ);
  c_save: cover property (CFG_SAVE);
  c_pass: cover property (CAL_PASS);
endmodule : cmd_parser_asserts

bind serial_config_command_parser cmd_parser_asserts chk_u (
  .CORE_CLK, .RESET, .RX_VALID, .RX_DATA, .CAL_START, .DECODE_OK,
  .CFG_APPLY, .CFG_SAVE, .STATUS_REQ, .PROTO_RESET, .PROTO_REQUEST,
  .PROTO_STX, .PROTO_ETX, .PROTO_ACK, .PROTO_NAK, .TX_PAUSED, .CAL_PASS
);

/* File: verification/host_link.sv */
`timescale 1ns/1ps
module host_link (
  // Clock
  input  wire logic       CORE_CLK,
  // Byte stream toward the parser
  output logic            RX_VALID,
  output logic      [7:0] RX_DATA
);
  initial begin
    RX_VALID = 1'b0;
    RX_DATA  = 8'h00;
  end
  // Idle data is the inverse of the last byte so stale values never match.
  task send_byte(input logic [7:0] b);
    @(posedge CORE_CLK);
    RX_VALID <= 1'b1;
    RX_DATA  <= b;
    @(posedge CORE_CLK);
    RX_VALID <= 1'b0;
    RX_DATA  <= ~b;
  endtask : send_byte
  // Strings go out as given: one comma, no space, leading fields kept.
  // A NUL goes out only through send_byte when a scenario asks.
  task send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);
      if (s[i] == ">") repeat (9) @(posedge CORE_CLK);
    end
  endtask : send_str
endmodule : host_link

/* File: verification/test_serial_config_command_parser.sv */
`timescale 1ns/1ps
module test_serial_config_command_parser
  import cmd_parser_pkg::*;
;
  logic       CORE_CLK = 1'b0;
  logic       RESET, CAL_START, CAL_END, DECODE_OK, RX_VALID;
  logic [7:0] RX_DATA, RD_DATA;
  logic [4:0] RD_ADDR;
  logic       CFG_APPLY, CFG_SAVE, STATUS_REQ, QUERY_REQ, CMD_ERROR;
  logic [11:0] QUERY_CODE;
  logic       PROTO_RESET, PROTO_REQUEST, PROTO_STX, PROTO_ETX;
  logic       PROTO_ACK, PROTO_NAK, TX_PAUSED, CAL_PASS, CAL_FAIL;
  logic [7:0] apply_n, save_n, stat_n, query_n, err_n, pass_n, fail_n;
  int         bad_count = 0;
  int         num_checks = 0;
  always #50 CORE_CLK = ~CORE_CLK;
  serial_config_command_parser dut_u (
    .CORE_CLK, .RESET, .RX_VALID, .RX_DATA, .RD_ADDR, .RD_DATA,
    .CFG_APPLY, .CFG_SAVE, .STATUS_REQ, .QUERY_REQ, .QUERY_CODE,
    .CMD_ERROR, .PROTO_RESET, .PROTO_REQUEST, .PROTO_STX, .PROTO_ETX,
    .PROTO_ACK, .PROTO_NAK, .TX_PAUSED, .CAL_START, .CAL_END,
    .DECODE_OK, .CAL_PASS, .CAL_FAIL);
  host_link host_u (.CORE_CLK, .RX_VALID, .RX_DATA);
  // Pulses are counted so multi-byte strings need no cycle-exact sampling.
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      {apply_n, save_n, stat_n, query_n} <= 32'h0000_0000;
      {err_n, pass_n, fail_n} <= 24'h00_0000;
    end else begin
      apply_n <= apply_n + {7'h00, CFG_APPLY};
      save_n  <= save_n + {7'h00, CFG_SAVE};
      stat_n  <= stat_n + {7'h00, STATUS_REQ};
      query_n <= query_n + {7'h00, QUERY_REQ};
      err_n   <= err_n + {7'h00, CMD_ERROR};
      pass_n  <= pass_n + {7'h00, CAL_PASS};
      fail_n  <= fail_n + {7'h00, CAL_FAIL};
    end
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
    num_checks++;
    if (seen !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task rd(input logic [1:0] g, input logic [2:0] f, input logic [7:0] e);
    @(posedge CORE_CLK);
    RD_ADDR <= {g, f};
    repeat (2) @(posedge CORE_CLK);
    #1 chk("stored field", {8'h00, RD_DATA}, {8'h00, e});
  endtask : rd
  task t_fields;
    host_u.send_str("<K100,3,5>");
    rd(2'h0, 3'h0, 8'h33);
    host_u.send_str("<K100,,7>");
    rd(2'h0, 3'h0, 8'h33);
    rd(2'h0, 3'h1, 8'h37);
    host_u.send_str("<K100,9>");
    rd(2'h0, 3'h0, 8'h39);
    rd(2'h0, 3'h1, 8'h37);
  endtask : t_fields
  task t_concat;
    logic [7:0] a0, s0;
    a0 = apply_n;
    s0 = save_n;
    host_u.send_str("<K145,1><K142,\\3E><Z>");
    rd(2'h3, 3'h0, 8'h31);
    rd(2'h2, 3'h0, 8'h3E);
    chk("apply count", 16'(apply_n - a0), 16'h0001);
    chk("save count", 16'(save_n - s0), 16'h0001);
    host_u.send_str("<A>");
    chk("apply count", 16'(apply_n - a0), 16'h0002);
    chk("save count", 16'(save_n - s0), 16'h0001);
  endtask : t_concat
  task t_ctrl;
    host_u.send_str("<K141,\015,\012,\023>");
    rd(2'h1, 3'h0, 8'h0D);
    rd(2'h1, 3'h1, 8'h0A);
    rd(2'h1, 3'h2, 8'h13);
    chk("paused", {15'h0000, TX_PAUSED}, 16'h0000);
  endtask : t_ctrl
  task t_query;
    logic [7:0] s0, q0;
    s0 = stat_n;
    q0 = query_n;
    host_u.send_str("<?>");
    chk("status count", 16'(stat_n - s0), 16'h0001);
    host_u.send_str("<K142?>");
    chk("query count", 16'(query_n - q0), 16'h0001);
    chk("query code", {4'h0, QUERY_CODE}, 16'h0142);
  endtask : t_query
  task t_proto;
    logic [7:0] codes [6];
    codes = '{PC_RESET, PC_REQ, PC_STX, PC_ETX, PC_ACK, PC_NAK};
    for (int i = 0; i < 6; i++) begin
      host_u.send_byte(codes[i]);
      #1 chk("protocol", {10'h000, PROTO_RESET, PROTO_REQUEST, PROTO_STX,
        PROTO_ETX, PROTO_ACK, PROTO_NAK}, 16'h0020 >> i);
    end
    host_u.send_byte(PC_XOFF);
    #1 chk("paused", {15'h0000, TX_PAUSED}, 16'h0001);
    host_u.send_byte(PC_XON);
    #1 chk("paused", {15'h0000, TX_PAUSED}, 16'h0000);
  endtask : t_proto
  task t_errors;
    logic [7:0] e0, s0, a0;
    e0 = err_n;
    s0 = stat_n;
    a0 = apply_n;
    host_u.send_str("<k100,5>");
    host_u.send_byte(PC_ACK);
    #1 chk("protocol", {15'h0000, PROTO_ACK}, 16'h0001);
    host_u.send_str("<K999,5>");
    host_u.send_str("<K100,\\G1>");
    host_u.send_str("<K100,6");
    host_u.send_byte(CH_NUL);
    host_u.send_str("><Z");
    host_u.send_byte(CH_NUL);
    host_u.send_str("<?>");
    host_u.send_str("<K100,4<?>");
    chk("error count", 16'(err_n - e0), 16'h0006);
    chk("status count", 16'(stat_n - s0), 16'h0002);
    chk("apply count", 16'(apply_n - a0), 16'h0000);
    rd(2'h0, 3'h0, 8'h39);
  endtask : t_errors
  task cal_run(input logic ok);
    @(posedge CORE_CLK);
    CAL_START <= 1'b1;
    @(posedge CORE_CLK);
    CAL_START <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    CAL_END   <= 1'b1;
    DECODE_OK <= ok;
    @(posedge CORE_CLK);
    CAL_END   <= 1'b0;
    DECODE_OK <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
  endtask : cal_run
  task t_cal;
    cal_run(1'b0);
    chk("cal fail", {pass_n, fail_n}, 16'h0001);
    cal_run(1'b1);
    chk("cal pass", {pass_n, fail_n}, 16'h0101);
  endtask : t_cal
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  initial begin
    RESET     = 1'b1;
    RD_ADDR   = 5'h00;
    CAL_START = 1'b0;
    CAL_END   = 1'b0;
    DECODE_OK = 1'b0;
    repeat (6) @(posedge CORE_CLK);
    RESET <= 1'b0;
    t_fields;
    t_concat;
    t_ctrl;
    t_query;
    t_proto;
    t_errors;
    t_cal;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    bad_count++;
    summarize;
  end
endmodule : test_serial_config_command_parser
